// ==== llg_pkg.sv ====
// shared constants and types, plus the per-quantity extreme tracker
`timescale 1ns/1ps
package llg_pkg;
  localparam int          CLK_PERIOD_NS  = 5;
  localparam int          SECOND_NS      = 1000000000;
  localparam int          SEC_CYCLES     = SECOND_NS / CLK_PERIOD_NS;
  localparam logic [15:0] LOG_EN_CMD     = 16'h0021;
  localparam logic [15:0] LOCK_KEY_DFLT  = 16'h0020;
  localparam logic [7:0]  LOG_BLOCK_CODE = 8'h04;
  localparam logic [7:0]  LOG_SUBCLASS   = 8'h3b;
  localparam logic [7:0]  RES_SUBCLASS   = 8'h42;

  typedef enum logic [1:0] {
    LV_FULL,
    LV_PARTLY_OPEN,
    LV_SEALED
  } llg_level_t;

  typedef enum logic {
    LG_IDLE,
    LG_WINDOW
  } llg_log_state_t;

  typedef struct packed {
    logic signed [15:0] hi;
    logic signed [15:0] lo;
  } llg_chan_t;

  typedef struct packed {
    llg_chan_t temp;
    llg_chan_t volt;
    llg_chan_t curr;
  } llg_table_t;

  typedef struct packed {
    logic signed [15:0] temp;
    logic signed [15:0] volt;
    logic signed [15:0] curr;
  } llg_meas_t;

  typedef struct packed {
    logic [15:0] temp;
    logic [15:0] volt;
    logic [15:0] curr;
  } llg_delta_t;

  typedef struct packed {
    logic flash_rw;
    logic mfg_a_rd;
    logic mfg_a_wr;
    logic mfg_bc_rw;
    logic key_rw;
    logic lifetime_rw;
    logic lifetime_via_block;
    logic resolution_wr;
  } llg_access_t;

  // gates while sealed: block A read, B/C r/w, lifetime through block
  localparam llg_access_t ACCESS_SEALED = 8'h56;
endpackage

// tracks running max/min of one quantity and flags a beyond-delta move
module llg_track (
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire logic signed [15:0]  sample,
  input  wire logic                sample_stb,
  input  wire logic [15:0]         delta,
  input  wire llg_pkg::llg_chan_t  nv,
  input  wire logic                load,
  output llg_pkg::llg_chan_t       ram,
  output logic                     trig
);
  import llg_pkg::*;

  llg_chan_t          next_ram;
  logic signed [16:0] up_dist;
  logic signed [16:0] dn_dist;
  logic signed [16:0] lim;

  // distance past the stored extremes, one bit wider to avoid wrap
  always_comb begin
    up_dist = {sample[15], sample} - {nv.hi[15], nv.hi};
    dn_dist = {nv.lo[15], nv.lo} - {sample[15], sample};
    lim     = {1'b0, delta};
    trig    = sample_stb && ((up_dist > 17'sd0 && up_dist > lim) ||
                             (dn_dist > 17'sd0 && dn_dist > lim));
  end

  // ram extremes follow every new extreme, no resolution applied
  always_comb begin
    next_ram = ram;
    if (load) begin
      next_ram = nv;
    end else if (sample_stb) begin
      if (sample > ram.hi) begin
        next_ram.hi = sample;
      end
      if (sample < ram.lo) begin
        next_ram.lo = sample;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ram <= '0;
    end else begin
      ram <= next_ram;
    end
  end
endmodule

// ==== llg_logger.sv ====
// lifetime min/max logger with three-level security gate
`timescale 1ns/1ps
module llg_logger #(
  parameter int          TICK_CYCLES = llg_pkg::SEC_CYCLES,
  parameter logic [15:0] LOCK_KEY    = llg_pkg::LOCK_KEY_DFLT
) (
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire logic                ctrl_wr,
  input  wire logic [15:0]         ctrl_data,
  input  wire logic [31:0]         unseal_key,
  input  wire logic [31:0]         full_key,
  input  wire logic [15:0]         log_window_time,
  input  wire llg_pkg::llg_delta_t delta,
  input  wire llg_pkg::llg_meas_t  meas,
  input  wire llg_pkg::llg_table_t nv_in,
  output llg_pkg::llg_table_t      nv_out,
  output logic                     nv_wr,
  output logic                     log_enabled,
  output logic                     window_open,
  output llg_pkg::llg_level_t      level,
  output logic                     sealed_flag,
  output logic                     full_access_locked_flag,
  output llg_pkg::llg_access_t     access,
  output logic [7:0]               log_block_code
);
  import llg_pkg::*;

  // second timer and logging window
  logic [27:0]    sec_cnt;
  logic [27:0]    next_sec_cnt;
  logic           tick;
  logic           log_active;
  logic           next_log_enabled;

  // logging window and storage write
  llg_log_state_t lg;
  llg_log_state_t next_lg;
  logic [15:0]    win_left;
  logic [15:0]    next_win_left;
  llg_table_t     next_nv_out;
  logic           next_nv_wr;
  logic           next_window_open;

  // ram table and its trackers
  logic           load_pend;
  llg_table_t     ram;
  logic [2:0]     trig;

  // security state
  llg_level_t     next_level;
  logic           next_sealed_flag;
  logic           next_locked_flag;
  logic           pend_unseal;
  logic           next_pend_unseal;
  logic           pend_full;
  logic           next_pend_full;
  llg_access_t    next_access;

  // one tracker per quantity; current hi is max charge, lo is max discharge
  // the ram table is the live record; storage sees it only on a flush
  llg_track u_temp (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .sample     (meas.temp),
    .sample_stb (tick),
    .delta      (delta.temp),
    .nv         (nv_in.temp),
    .load       (load_pend),
    .ram        (ram.temp),
    .trig       (trig[0])
  );

  llg_track u_volt (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .sample     (meas.volt),
    .sample_stb (tick),
    .delta      (delta.volt),
    .nv         (nv_in.volt),
    .load       (load_pend),
    .ram        (ram.volt),
    .trig       (trig[1])
  );

  llg_track u_curr (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .sample     (meas.curr),
    .sample_stb (tick),
    .delta      (delta.curr),
    .nv         (nv_in.curr),
    .load       (load_pend),
    .ram        (ram.curr),
    .trig       (trig[2])
  );

  // logging is live only with the enable seen and a nonzero window
  // without both, the second counter and the window machine stay idle
  always_comb begin
    log_active = log_enabled && (log_window_time != 16'h0000);
    tick       = log_active &&
                 (sec_cnt == 28'(TICK_CYCLES - 1));
  end

  // second counter, held at zero while logging is off
  // restarting from zero makes the first tick a full second after start
  always_comb begin
    next_sec_cnt = sec_cnt + 28'h0000001;
    if (!log_active || tick) begin
      next_sec_cnt = 28'h0000000;
    end
  end

  // enable latches on the logging subcommand
  always_comb begin
    next_log_enabled = log_enabled;
    if (ctrl_wr && ctrl_data == LOG_EN_CMD) begin
      next_log_enabled = 1'b1;
    end
  end

  // window machine: trigger opens, end of window flushes the ram table
  // a flush drops back to idle and a new window needs a fresh trigger,
  // so two flushes are always at least one whole window apart
  always_comb begin
    next_lg       = lg;
    next_win_left = win_left;
    next_nv_out   = nv_out;
    next_nv_wr    = 1'b0;
    case (lg)
      LG_IDLE: begin
        if (tick && trig != 3'h0) begin
          next_lg       = LG_WINDOW;
          next_win_left = log_window_time;
        end
      end
      LG_WINDOW: begin
        if (!log_active) begin
          next_lg = LG_IDLE;
        end else if (tick) begin
          if (win_left <= 16'h0001) begin
            next_nv_out = ram;
            next_nv_wr  = 1'b1;
            next_lg     = LG_IDLE;
          end else begin
            next_win_left = win_left - 16'h0001;
          end
        end
      end
      default: begin
        next_lg = LG_IDLE;
      end
    endcase
    next_window_open = (next_lg == LG_WINDOW);
  end

  // starting values: ram reloads from storage once after reset release,
  // so storage edits only survive if reset lands before the next flush
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      load_pend <= 1'b1;
    end else begin
      load_pend <= 1'b0;
    end
  end

  // second counter register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sec_cnt <= 28'h0000000;
    end else begin
      sec_cnt <= next_sec_cnt;
    end
  end

  // enable register, cleared only by reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      log_enabled <= 1'b0;
    end else begin
      log_enabled <= next_log_enabled;
    end
  end

  // window state and the storage write port;
  // nv_out keeps the flushed table after the write pulse
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lg          <= LG_IDLE;
      win_left    <= 16'h0000;
      nv_out      <= '0;
      nv_wr       <= 1'b0;
      window_open <= 1'b0;
    end else begin
      lg          <= next_lg;
      win_left    <= next_win_left;
      nv_out      <= next_nv_out;
      nv_wr       <= next_nv_wr;
      window_open <= next_window_open;
    end
  end

  // key words: low half first, high half on the very next control write
  // a stray word between the halves drops the pair, so a half cannot
  // linger and be completed later by an unrelated write
  always_comb begin
    next_level       = level;
    next_sealed_flag = sealed_flag;
    next_locked_flag = full_access_locked_flag;
    next_pend_unseal = 1'b0;
    next_pend_full   = 1'b0;
    if (ctrl_wr) begin
      if (level != LV_SEALED && ctrl_data == LOCK_KEY) begin
        next_level       = LV_SEALED;
        next_sealed_flag = 1'b1;
        next_locked_flag = 1'b1;
      end else if (level == LV_SEALED) begin
        if (pend_unseal && ctrl_data == unseal_key[31:16]) begin
          next_level       = LV_PARTLY_OPEN;
          next_sealed_flag = 1'b0;
        end else if (ctrl_data == unseal_key[15:0]) begin
          next_pend_unseal = 1'b1;
        end
      end else if (level == LV_PARTLY_OPEN) begin
        if (pend_full && ctrl_data == full_key[31:16]) begin
          next_level       = LV_FULL;
          next_locked_flag = 1'b0;
        end else if (ctrl_data == full_key[15:0]) begin
          next_pend_full = 1'b1;
        end
      end
      // any other word simply drops the pending half, level untouched
    end else begin
      next_pend_unseal = pend_unseal;
      next_pend_full   = pend_full;
    end
  end

  // access gates decoded from the level being entered
  // decoding next_level keeps the gates in step with the level register
  always_comb begin
    next_access                    = '0;
    next_access.lifetime_rw        = 1'b1;
    next_access.lifetime_via_block = (next_level == LV_SEALED);
    next_access.mfg_a_rd           = 1'b1;
    next_access.mfg_bc_rw          = 1'b1;
    if (next_level != LV_SEALED) begin
      next_access.flash_rw      = 1'b1;
      next_access.mfg_a_wr      = 1'b1;
      next_access.resolution_wr = 1'b1;
    end
    next_access.key_rw = (next_level == LV_FULL);
  end

  // reset always lands in sealed
  // pending halves clear too, so no key half survives a reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      level                   <= LV_SEALED;
      sealed_flag             <= 1'b1;
      full_access_locked_flag <= 1'b1;
      pend_unseal             <= 1'b0;
      pend_full               <= 1'b0;
    end else begin
      level                   <= next_level;
      sealed_flag             <= next_sealed_flag;
      full_access_locked_flag <= next_locked_flag;
      pend_unseal             <= next_pend_unseal;
      pend_full               <= next_pend_full;
    end
  end

  // access gates and block code; reset value matches the sealed decode
  // so while reset is held only the sealed rights show, B/C and lifetime r/w among them
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      access         <= ACCESS_SEALED;
      log_block_code <= LOG_BLOCK_CODE;
    end else begin
      access         <= next_access;
      log_block_code <= LOG_BLOCK_CODE;
    end
  end
endmodule

// ==== llg_logger_chk.sv ====
// port checker for the lifetime logger, bound to its top module
`timescale 1ns/1ps
module llg_logger_chk
  import llg_pkg::*;
#(
  parameter int          TICK_CYCLES = 20,
  parameter logic [15:0] LOCK_KEY    = 16'h0020
) (
  input wire logic                 ref_clk,
  input wire logic                 rst,
  input wire logic                 ctrl_wr,
  input wire logic [15:0]          ctrl_data,
  input wire logic [31:0]          unseal_key,
  input wire logic [15:0]          log_window_time,
  input wire logic                 nv_wr,
  input wire logic                 log_enabled,
  input wire logic                 window_open,
  input wire llg_pkg::llg_level_t  level,
  input wire logic                 sealed_flag,
  input wire logic                 full_access_locked_flag,
  input wire llg_pkg::llg_access_t access
);
  logic [31:0] gap;
  logic [31:0] next_gap;
  // cycles since the last storage write, saturating
  always_comb begin
    next_gap = nv_wr ? 32'h0 : (&gap ? gap : gap + 32'h1);
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gap <= 32'hffff_ffff;
    end else begin
      gap <= next_gap;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // two key words on consecutive strobes, low half first
  sequence unseal_pair;
    ctrl_wr && ctrl_data == unseal_key[15:0] ##1
    ctrl_wr && ctrl_data == unseal_key[31:16];
  endsequence
  a_unseal_pair: assert property (
    level == LV_SEALED ##0 unseal_pair |=> level == LV_PARTLY_OPEN)
    else $error("unseal pair did not open");
  a_wrong_word: assert property (
    level == LV_SEALED && ctrl_wr && ctrl_data != unseal_key[31:16]
    |=> level == LV_SEALED) else $error("level left sealed");
  a_seal_key: assert property (
    ctrl_wr && ctrl_data == LOCK_KEY && level != LV_SEALED |=>
    level == LV_SEALED && sealed_flag && full_access_locked_flag)
    else $error("lock key not obeyed");
  a_enable_cmd: assert property (
    ctrl_wr && ctrl_data == LOG_EN_CMD |=> log_enabled)
    else $error("logging not enabled");
  a_idle_quiet: assert property (
    !log_enabled |-> !window_open && !nv_wr)
    else $error("logging active while disabled");
  a_sealed_rights: assert property (
    level == LV_SEALED |-> access == 8'h56)
    else $error("sealed access wrong");
  a_key_access: assert property (
    access.key_rw == (level == LV_FULL)) else $error("key access wrong");
  a_res_access: assert property (
    access.resolution_wr == (level != LV_SEALED))
    else $error("resolution access wrong");
  a_write_gap: assert property (
    nv_wr |-> gap >= TICK_CYCLES * log_window_time)
    else $error("storage writes too close");
  a_window_end: assert property (
    nv_wr |-> $past(window_open)) else $error("write outside window");
endmodule

bind llg_logger llg_logger_chk #(
  .TICK_CYCLES(TICK_CYCLES),
  .LOCK_KEY   (LOCK_KEY)
) llg_logger_chk_inst (
  .ref_clk(ref_clk), .rst(rst), .ctrl_wr(ctrl_wr), .ctrl_data(ctrl_data),
  .unseal_key(unseal_key), .log_window_time(log_window_time),
  .nv_wr(nv_wr), .log_enabled(log_enabled), .window_open(window_open),
  .level(level), .sealed_flag(sealed_flag), .access(access),
  .full_access_locked_flag(full_access_locked_flag)
);

// ==== llg_host.sv ====
// host model writing control words and two-word keys
`timescale 1ns/1ps
module llg_host (
  input  wire logic   ref_clk,
  output logic        ctrl_wr,
  output logic [15:0] ctrl_data
);
  // idle bus shows the inverse of the last word
  initial begin
    ctrl_wr   = 1'b0;
    ctrl_data = 16'h0000;
  end
  // one control word, strobe for one cycle
  task automatic word(input logic [15:0] w);
    @(posedge ref_clk);
    ctrl_wr   <= 1'b1;
    ctrl_data <= w;
    @(posedge ref_clk);
    ctrl_wr   <= 1'b0;
    ctrl_data <= ~w;
  endtask
  // key words back to back; swap sends them in the wrong order
  task automatic key(input logic [31:0] k, input logic swap);
    @(posedge ref_clk);
    ctrl_wr   <= 1'b1;
    ctrl_data <= swap ? k[31:16] : k[15:0];
    @(posedge ref_clk);
    ctrl_data <= swap ? k[15:0] : k[31:16];
    @(posedge ref_clk);
    ctrl_wr   <= 1'b0;
    ctrl_data <= ~ctrl_data;
  endtask
endmodule

// ==== llg_logger_test.sv ====
// self-checking bench for the lifetime logger
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin \
  miscompares++; $display("wrong value %s exp %h got %h", nm, ex, got); end end
module llg_logger_test;
  import llg_pkg::*;
  localparam int          TICK = 20;
  localparam logic [31:0] UKEY = 32'h5a3c_1e47;
  localparam logic [31:0] FKEY = 32'h7b21_c4d9;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        ctrl_wr;
  logic [15:0] ctrl_data;
  logic [15:0] log_window_time = 16'h0000;
  llg_delta_t  delta = {16'h0010, 16'h0032, 16'h0064};
  llg_meas_t   meas = {16'h0032, 16'h0dac, 16'h0000};
  llg_table_t  nv_in;
  llg_table_t  nv_out;
  llg_table_t  exp_t;
  llg_level_t  level;
  llg_level_t  prev_level;
  llg_level_t  exp_l;
  llg_access_t access;
  logic        nv_wr;
  logic        log_enabled;
  logic        window_open;
  logic        sealed_flag;
  logic        locked;
  logic [7:0]  block_code;
  logic [15:0] r;
  llg_level_t  lq[$];
  llg_table_t  tq[$];
  int          seed = 72;
  int          miscompares = 0;
  int          samples_checked = 0;
  always #2.5 ref_clk = ~ref_clk;
  llg_host llg_host_inst (.ref_clk(ref_clk), .ctrl_wr(ctrl_wr),
    .ctrl_data(ctrl_data));
  llg_logger #(.TICK_CYCLES(TICK)) llg_logger_inst (
    .ref_clk(ref_clk), .rst(rst), .ctrl_wr(ctrl_wr), .ctrl_data(ctrl_data),
    .unseal_key(UKEY), .full_key(FKEY), .log_window_time(log_window_time),
    .delta(delta), .meas(meas), .nv_in(nv_in), .nv_out(nv_out),
    .nv_wr(nv_wr), .log_enabled(log_enabled), .window_open(window_open),
    .level(level), .sealed_flag(sealed_flag), .access(access),
    .full_access_locked_flag(locked), .log_block_code(block_code));
  // watcher: level changes and storage writes against the oldest notes
  always @(posedge ref_clk) begin
    prev_level <= level;
    if (!rst && level !== prev_level) begin
      exp_l = lq.size() ? lq.pop_front() : prev_level;
      `CHK("level", exp_l, level)
    end
    if (!rst && nv_wr) begin
      exp_t = tq.size() ? tq.pop_front() : nv_in;
      `CHK("table", exp_t, nv_out)
      nv_in <= nv_out;
    end
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // bounded wait until every note has been consumed
  task automatic settle(input int n);
    for (int i = 0; i < n && (lq.size() || tq.size()); i++)
      @(posedge ref_clk);
    repeat (2) @(posedge ref_clk);
    if (lq.size() || tq.size()) begin
      miscompares++;
      $display("wrong value result exp seen got none");
      wrap_up;
    end
  endtask
  initial begin
    nv_in = {16'h0064, 16'h0000, 16'h0fa0, 16'h0bb8, 16'h01f4, 16'hfe0c};
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    // refused: swapped halves, lock while sealed, full key while sealed
    llg_host_inst.key(UKEY, 1'b1);
    llg_host_inst.word(LOCK_KEY_DFLT);
    llg_host_inst.key(FKEY, 1'b0);
    settle(4);
    lq.push_back(LV_PARTLY_OPEN);
    llg_host_inst.key(UKEY, 1'b0);
    settle(8);
    `CHK("flash", 1'b1, access.flash_rw)
    lq.push_back(LV_FULL);
    llg_host_inst.key(FKEY, 1'b0);
    settle(8);
    `CHK("key_rw", 1'b1, access.key_rw)
    lq.push_back(LV_SEALED);
    llg_host_inst.word(LOCK_KEY_DFLT);
    settle(8);
    `CHK("flags", 2'h3, {sealed_flag, locked})
    `CHK("access", 8'h56, access)
    $display("security test done");
    // trigger on volt, sub-delta temp and curr extremes
    r = 16'h0001 + {13'h0, 3'($random(seed))};
    meas <= {16'h0064 + r, 16'h1004, 16'hfdf8};
    llg_host_inst.word(LOG_EN_CMD);
    repeat (3 * TICK) @(posedge ref_clk);
    `CHK("enabled", 1'b1, log_enabled)
    tq.push_back({16'h0064 + r, 16'h0000, 16'h1004, 16'h0bb8,
                  16'h01f4, 16'hfdf8});
    log_window_time <= 16'h0002;
    repeat (2 * TICK) @(posedge ref_clk);
    `CHK("window", 1'b1, window_open)
    settle(8 * TICK);
    $display("logging test done");
    lq.push_back(LV_PARTLY_OPEN);
    llg_host_inst.key(UKEY, 1'b0);
    settle(8);
    rst <= 1'b1;
    @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    `CHK("reset level", LV_SEALED, level)
    `CHK("block code", 8'h04, block_code)
    $display("reset test done");
    wrap_up;
  end
endmodule
